// >>> hw/sfrs_pkg.sv
// Constants and types for the SPI frame response sequencer.
// Assumes one 16-bit command per frame and a register file outside the block.
package sfrs_pkg;

  // ************************************************************
  // Frame geometry
  // ************************************************************
  localparam int unsigned CMD_W   = 16;
  localparam int unsigned CNT_W   = 8;
  // Clock counts that make a good transfer: 16 plus 0, 1 or 2 bytes
  localparam logic [7:0]  LEN_ONE = 8'h10;
  localparam logic [7:0]  LEN_TWO = 8'h18;
  localparam logic [7:0]  LEN_TRI = 8'h20;
  localparam logic [7:0]  LEN_SAT = 8'hff;

  // ************************************************************
  // Field positions in command and reply words
  // ************************************************************
  localparam int unsigned PFX_HI  = 15;
  localparam int unsigned PFX_LO  = 14;
  localparam int unsigned ADR_HI  = 13;
  localparam int unsigned ADR_LO  = 10;
  localparam int unsigned SUB_HI  = 9;
  localparam int unsigned SUB_LO  = 8;
  localparam int unsigned DAT_HI  = 7;
  localparam int unsigned CON_HI  = 9;
  localparam int unsigned TER_BIT = 10;

  // ************************************************************
  // Prefix codes
  // ************************************************************
  localparam logic [1:0]  PFX_WRITE     = 2'h2;
  localparam logic [1:0]  PFX_READ      = 2'h1;
  localparam logic [1:0]  PFX_BAD_WRITE = 2'h3;
  localparam logic [1:0]  PFX_BAD_READ  = 2'h0;
  localparam logic [1:0]  PFX_ECHO      = 2'h2;

  // Primary address locations that exist; a clear bit is reserved
  localparam logic [15:0] ADDR_VALID = 16'h7fff;

  // ************************************************************
  // Synchroniser lanes and their idle values
  // ************************************************************
  localparam int unsigned SYNC_N     = 2;
  localparam int unsigned CS_IDX     = 0;
  localparam int unsigned TGL_IDX    = 1;
  localparam logic [1:0]  SYNC_RESET = 2'h1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EVAL = 2'b01,
    ST_LOAD = 2'b10
  } sfrs_state_t;

  typedef enum logic [1:0] {
    KIND_DIAG  = 2'b00,
    KIND_READ  = 2'b01,
    KIND_FAULT = 2'b10
  } sfrs_kind_t;

  // Register access issued toward the register file
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] primary_address_field;
    logic [1:0] secondary_address_field;
    logic [7:0] data;
  } sfrs_cmd_t;

endpackage

// >>> hw/sfrs_sequencer.sv
// Frame-level sequencer of a 16-bit SPI slave: shifting, frame checks, reply choice.
// Assumes the master idles the serial clock low and stops it while chip select is high.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Reply to a command is shifted out during the next frame, not the same one.
// - Clock count other than 16, 24 or 32 is a transfer fault.
// - First reply after power-on or software reset is a special frame.
// - Write with prefix 11 is a syntax error; special reply follows.
// - Read with prefix 00 is a syntax error; special reply follows.
// - Access to a reserved address is a syntax error; special reply follows.
// - Reset reply is command status with fault flag set; next is normal diagnosis.
// - Fault flag is bit 10, cleared only after 16, 24 or 32 clocks.
// - Write starts 10, read 01; read reply echoes 10 and address.
module sfrs_sequencer
  import sfrs_pkg::*;
(
  // System clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        soft_reset,
  // Serial link pins
  input  wire logic        serial_clock,
  input  wire logic        chip_select_n,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_en,
  // Register file side
  output sfrs_cmd_t        cmd,
  input  wire logic [9:0]  read_content,
  input  wire logic [15:0] std_diag,
  input  wire logic [15:0] command_status_register,
  output logic             transfer_fault_flag
);

  // ************************************************************
  // Link clock domain
  // ************************************************************
  logic             in_frame;
  logic [CNT_W-1:0] bit_count;
  logic [CMD_W-1:0] rx_shift;
  logic             tx_toggle;

  // Frame marker, cleared by chip select so a new frame restarts the count
  always_ff @(negedge serial_clock or posedge chip_select_n)
  begin
    if (chip_select_n)
      in_frame <= 1'b0;
    else
      in_frame <= 1'b1;
  end

  // Sample on falling edges; count survives chip select for the system side
  always_ff @(negedge serial_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_count <= '0;
      rx_shift  <= '0;
    end
    else
    begin
      rx_shift <= {rx_shift[CMD_W-2:0], serial_in};
      if (!in_frame)
        bit_count <= 8'h01;
      else if (bit_count != LEN_SAT)
        bit_count <= bit_count + 8'h01;
    end
  end

  // One toggle per rising edge carries the shift event across
  always_ff @(posedge serial_clock or negedge rst_n)
  begin
    if (!rst_n)
      tx_toggle <= 1'b0;
    else
      tx_toggle <= ~tx_toggle;
  end

  // ************************************************************
  // Crossing into the system clock domain
  // ************************************************************
  logic [SYNC_N-1:0] sync1;
  logic [SYNC_N-1:0] sync2;
  logic [SYNC_N-1:0] sync3;
  logic [SYNC_N-1:0] filt;
  logic [SYNC_N-1:0] change;
  logic [SYNC_N-1:0] raw_in;

  assign raw_in = {tx_toggle, chip_select_n};

  // Three stages; a change counts only when stages two and three agree
  for (genvar i = 0; i < SYNC_N; i++)
  begin : g_sync
    always_ff @(posedge clock)
    begin
      if (!rst_n)
      begin
        sync1[i] <= SYNC_RESET[i];
        sync2[i] <= SYNC_RESET[i];
        sync3[i] <= SYNC_RESET[i];
        filt[i]  <= SYNC_RESET[i];
      end
      else
      begin
        sync1[i] <= raw_in[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (change[i])
          filt[i] <= sync3[i];
      end
    end
    assign change[i] = (sync2[i] == sync3[i]) && (sync3[i] != filt[i]);
  end

  logic frame_start;
  logic frame_end;
  logic shift_event;

  assign frame_start = change[CS_IDX] && !sync3[CS_IDX];
  assign frame_end   = change[CS_IDX] && sync3[CS_IDX];
  assign shift_event = change[TGL_IDX] && !filt[CS_IDX];

  // ************************************************************
  // Frame evaluation
  // ************************************************************
  sfrs_state_t      state;
  sfrs_kind_t       kind;
  logic [CMD_W-1:0] rx_hold;
  logic [CNT_W-1:0] len_hold;
  logic [CMD_W-1:0] reply_word;
  logic             reset_pending;
  logic             len_ok;
  logic             addr_ok;
  logic [1:0]       prefix;

  assign prefix  = rx_hold[PFX_HI:PFX_LO];
  assign len_ok  = (len_hold == LEN_ONE) || (len_hold == LEN_TWO) || (len_hold == LEN_TRI);
  assign addr_ok = ADDR_VALID[rx_hold[ADR_HI:ADR_LO]];

  // Link registers are quiet once chip select is seen high, so a plain copy is safe
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state    <= ST_IDLE;
      rx_hold  <= '0;
      len_hold <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (frame_end)
          begin
            rx_hold  <= rx_shift;
            len_hold <= bit_count;
            state    <= ST_EVAL;
          end
        end
        ST_EVAL: state <= ST_LOAD;
        ST_LOAD: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Decode: faults suppress the register access so a bad frame changes nothing
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cmd  <= '0;
      kind <= KIND_FAULT;
    end
    else
    begin
      cmd.wr <= 1'b0;
      cmd.rd <= 1'b0;
      if (state == ST_EVAL)
      begin
        cmd.primary_address_field   <= rx_hold[ADR_HI:ADR_LO];
        cmd.secondary_address_field <= rx_hold[SUB_HI:SUB_LO];
        cmd.data                    <= rx_hold[DAT_HI:0];
        if (!len_ok)
          kind <= KIND_FAULT;
        else if (prefix == PFX_BAD_WRITE || prefix == PFX_BAD_READ)
          kind <= KIND_FAULT;
        else if (!addr_ok)
          kind <= KIND_FAULT;
        else if (prefix == PFX_READ)
        begin
          kind   <= KIND_READ;
          cmd.rd <= 1'b1;
        end
        else
        begin
          kind   <= KIND_DIAG;
          cmd.wr <= 1'b1;
        end
      end
    end
  end

  // Reply for the next frame; read content is taken while the read strobe shows
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      reply_word          <= '0;
      transfer_fault_flag <= 1'b1;
    end
    else if (state == ST_LOAD)
    begin
      if (kind == KIND_READ)
      begin
        reply_word          <= {PFX_ECHO, cmd.primary_address_field, read_content};
        transfer_fault_flag <= 1'b0;
      end
      else
      begin
        reply_word          <= {1'b0, std_diag[CMD_W-2:0]};
        reply_word[TER_BIT] <= (kind == KIND_FAULT);
        transfer_fault_flag <= (kind == KIND_FAULT);
      end
    end
    else if (frame_start && reset_pending)
      transfer_fault_flag <= 1'b1;
  end

  // Special reset reply is owed until a frame starts; a new reset request wins
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      reset_pending <= 1'b1;
    else if (soft_reset)
      reset_pending <= 1'b1;
    else if (frame_start)
      reset_pending <= 1'b0;
  end

  // ************************************************************
  // Serial output
  // ************************************************************
  logic [CMD_W-1:0] tx_shift;
  logic [CMD_W-1:0] load_word;

  // Reset frame carries command status with the fault flag forced high
  always_comb
  begin
    load_word = reply_word;
    if (reset_pending)
    begin
      load_word          = {1'b0, command_status_register[CMD_W-2:0]};
      load_word[TER_BIT] = 1'b1;
    end
  end

  // First rising edge re-presents the top bit, so the master sees it on both sides
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      tx_shift      <= '0;
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end
    else if (frame_start)
    begin
      tx_shift      <= load_word;
      serial_out    <= load_word[CMD_W-1];
      serial_out_en <= 1'b1;
    end
    else if (frame_end)
      serial_out_en <= 1'b0;
    else if (shift_event)
    begin
      serial_out <= tx_shift[CMD_W-1];
      tx_shift   <= {tx_shift[CMD_W-2:0], 1'b0};
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_eval_load;
    state == ST_EVAL ##1 state == ST_LOAD ##1 state == ST_IDLE;
  endsequence

  sequence s_fault_reply;
    reply_word[TER_BIT] && !reply_word[CMD_W-1] && transfer_fault_flag;
  endsequence

  a_reply_load: assert property (frame_start |=> serial_out_en && tx_shift == $past(load_word))
    else $error("reply not loaded at frame start");

  a_len_fault: assert property ((state == ST_EVAL && !len_ok) |-> s_eval_load ##0 s_fault_reply)
    else $error("bad clock count did not give fault reply");

  a_reset_frame: assert property ((frame_start && reset_pending) |=> tx_shift[TER_BIT] && !tx_shift[CMD_W-1])
    else $error("reset reply lacks fault flag");

  a_bad_write: assert property ((state == ST_EVAL && prefix == PFX_BAD_WRITE) |=> !cmd.wr ##1 s_fault_reply)
    else $error("prefix 11 accepted");

  a_bad_read: assert property ((state == ST_EVAL && prefix == PFX_BAD_READ) |=> !cmd.rd ##1 s_fault_reply)
    else $error("prefix 00 accepted");

  a_bad_addr: assert property ((state == ST_EVAL && !addr_ok) |=> !cmd.wr && !cmd.rd ##1 s_fault_reply)
    else $error("reserved address accepted");

  a_ter_clear: assert property ((state == ST_EVAL && len_ok && addr_ok && prefix == PFX_WRITE)
                               |=> cmd.wr ##1 !reply_word[TER_BIT] && !transfer_fault_flag)
    else $error("fault flag set after good write");

  a_read_echo: assert property ((state == ST_EVAL && len_ok && addr_ok && prefix == PFX_READ)
                               |=> cmd.rd ##1 reply_word[PFX_HI:PFX_LO] == PFX_ECHO
                               && reply_word[ADR_HI:ADR_LO] == $past(rx_hold[ADR_HI:ADR_LO], 2))
    else $error("read reply does not echo address");

  a_oe_release: assert property (frame_end |=> !serial_out_en)
    else $error("output still driven after frame");

endmodule // sfrs_sequencer

`default_nettype wire

// >>> tb/sfrs_master.sv
// Behavioural SPI master that drives the link pins of the sequencer.
// Assumes the bench calls xfer for one frame at a time; link clock idles low.
`timescale 1ns/100ps
`default_nettype none

module sfrs_master
  import sfrs_pkg::*;
(
  // Link pins driven toward the slave
  output logic      serial_clock,
  output logic      chip_select_n,
  output logic      serial_in,
  // Link pins coming back from the slave
  input  wire logic serial_out,
  input  wire logic serial_out_en
);
  // ************************************************************
  // Frame timing, 160 ns link period
  // ************************************************************
  localparam int HALF = 80;

  // Last command sent, kept so the next reply can be decoded
  logic [15:0] prev_cmd;
  // High only if the enable stood at every sample of the last frame
  logic        en_all;

  // Idle: select high, clock stopped low, data pulled down
  initial
  begin
    serial_clock  = 1'b0;
    chip_select_n = 1'b1;
    serial_in     = 1'b0;
    prev_cmd      = 16'h0000;
    en_all        = 1'b0;
  end

  // One frame of nclk clocks, MSB first; reply sampled on falling clock
  task automatic xfer(input logic [31:0] tx, input int nclk, output logic [15:0] rx);
    rx = 16'h0000;
    en_all = 1'b1;
    chip_select_n = 1'b0;
    // Odd lead lets the link edges drift against the system clock
    #250.3;
    for (int k = nclk - 1; k >= 0; k--)
    begin
      serial_in = (k < 32) ? tx[k] : 1'b0;
      #10;
      serial_clock = 1'b1;
      #HALF;
      serial_clock = 1'b0;
      rx = {rx[14:0], serial_out};
      en_all = en_all & serial_out_en;
      #(HALF - 10);
    end
    // Lag above 200 ns, then a gap above 250 ns before any next frame
    #200;
    chip_select_n = 1'b1;
    serial_in     = 1'b0;
    prev_cmd      = tx[15:0];
    #300;
  endtask
endmodule // sfrs_master

`default_nettype wire

// >>> tb/sfrs_sequencer_tb_top.sv
// Self-checking bench for the frame response sequencer.
// Assumes the master model in sfrs_master.sv and a 250 MHz system clock.
`timescale 1ns/100ps
`default_nettype none

module sfrs_sequencer_tb_top
  import sfrs_pkg::*;
;
  // ************************************************************
  // Signals and expected reply words
  // ************************************************************
  localparam logic [15:0] DIAG    = 16'hc6a5;
  localparam logic [15:0] CSR     = 16'h8123;
  localparam logic [15:0] DIAG_OK = {1'b0, DIAG[14:11], 1'b0, DIAG[9:0]};
  localparam logic [15:0] DIAG_BAD = {1'b0, DIAG[14:11], 1'b1, DIAG[9:0]};
  localparam logic [15:0] RST_RPL = {1'b0, CSR[14:11], 1'b1, CSR[9:0]};
  localparam logic [15:0] WR_CMD  = 16'h845a;

  logic        clock;
  logic        rst_n;
  logic        soft_reset;
  wire         serial_clock;
  wire         chip_select_n;
  wire         serial_in;
  logic        serial_out;
  logic        serial_out_en;
  sfrs_cmd_t   cmd;
  logic [9:0]  read_content;
  logic [15:0] std_diag;
  logic [15:0] command_status_register;
  logic        transfer_fault_flag;
  logic [15:0] rx;
  int          num_errors = 0;
  int          num_checks = 0;
  int          strobes = 0;
  int          reads = 0;

  sfrs_sequencer i_dut (.clock, .rst_n, .soft_reset, .serial_clock, .chip_select_n, .serial_in,
                        .serial_out, .serial_out_en, .cmd, .read_content, .std_diag,
                        .command_status_register, .transfer_fault_flag);

  sfrs_master i_master (.serial_clock, .chip_select_n, .serial_in, .serial_out, .serial_out_en);

  // System clock, 4 ns period
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Register file stand-in: content derived from the address, counts strobes
  always @(negedge clock)
  begin
    read_content <= {cmd.primary_address_field, cmd.secondary_address_field, 4'h9};
    if (cmd.wr === 1'b1 || cmd.rd === 1'b1)
      strobes <= strobes + 1;
    if (cmd.rd === 1'b1)
      reads <= reads + 1;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic frame(input logic [31:0] tx, input int n);
    i_master.xfer(tx, n, rx);
    check({15'h0000, i_master.en_all}, 16'h0001, "enable in frame");
    check({15'h0000, serial_out_en}, 16'h0000, "enable after frame");
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset_reply(input string name);
    frame(WR_CMD, 16);
    check(rx, RST_RPL, "first reply");
    frame(WR_CMD, 16);
    check(rx, DIAG_OK, "second reply");
    check({8'h00, cmd.data}, 16'h005a, "write data");
    check({12'h000, cmd.primary_address_field}, 16'h0001, "write address");
    $display("test %s done", name);
  endtask

  task automatic t_read();
    int s0;
    int r0;
    s0 = strobes;
    r0 = reads;
    frame(32'h0000_4e02, 16);
    check(16'(strobes - s0), 16'h0001, "read strobe");
    check(16'(reads - r0), 16'h0001, "strobe is a read");
    check({14'h0000, cmd.secondary_address_field}, 16'h0002, "read sub address");
    check(i_master.prev_cmd, 16'h4e02, "kept command");
    frame(WR_CMD, 16);
    check(rx, {2'b10, 4'h3, 4'h3, 2'b10, 4'h9}, "read reply");
    $display("test read done");
  endtask

  task automatic t_counts();
    int n[8] = '{8, 16, 15, 24, 17, 40, 23, 32};
    int s0;
    logic good;
    for (int i = 0; i < 8; i++)
    begin
      good = (n[i] == 16 || n[i] == 24 || n[i] == 32);
      s0 = strobes;
      frame(WR_CMD, n[i]);
      check(16'(strobes - s0), {15'h0000, good}, "strobe per count");
      check({15'h0000, transfer_fault_flag}, {15'h0000, !good}, "fault flag");
      frame(WR_CMD, 16);
      check(rx, good ? DIAG_OK : DIAG_BAD, "reply after count");
    end
    $display("test counts done");
  endtask

  task automatic t_syntax();
    logic [15:0] c[4] = '{16'hc45a, 16'h0e02, 16'hbc5a, 16'h7e02};
    int s0;
    for (int i = 0; i < 4; i++)
    begin
      s0 = strobes;
      frame({16'h0000, c[i]}, 16);
      check(16'(strobes - s0), 16'h0000, "no access on bad command");
      frame(WR_CMD, 16);
      check(rx, DIAG_BAD, "reply after bad command");
    end
    $display("test syntax done");
  endtask

  task automatic t_soft_reset();
    @(negedge clock);
    soft_reset = 1'b1;
    @(negedge clock);
    soft_reset = 1'b0;
    repeat (8) @(negedge clock);
    t_reset_reply("soft_reset");
  endtask

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial
  begin
    rst_n = 1'b0;
    soft_reset = 1'b0;
    std_diag = DIAG;
    command_status_register = CSR;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    repeat (8) @(negedge clock);
    t_reset_reply("power_up");
    t_read();
    t_counts();
    t_syntax();
    t_soft_reset();
    report_and_stop();
  end

  // Whole run needs roughly 107 us of frames
  initial
  begin
    #300000;
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule // sfrs_sequencer_tb_top

`default_nettype wire
